// [acrb_pkg.sv]
package acrb_pkg;
  // Register offsets on the configuration port.
  localparam logic [7:0] ADDR_POWER_MODE = 8'h08;
  localparam logic [7:0] ADDR_SAMPLING_CLOCK = 8'h09;
  localparam logic [7:0] ADDR_TEST_PATTERN = 8'h0d;
  localparam logic [7:0] ADDR_DIGITAL_TRIM = 8'h10;
  localparam logic [7:0] ADDR_OUTPUT_CONFIG = 8'h14;
  localparam logic [7:0] ADDR_OUT_CLOCK_POL = 8'h16;
  localparam logic [7:0] ADDR_REFERENCE_SEL = 8'h18;
  localparam logic [7:0] ADDR_SHADOW_XFER = 8'hff;
  // Reset values.
  localparam logic [7:0] RST_POWER_MODE = 8'h00;
  localparam logic [7:0] RST_SAMPLING_CLOCK = 8'h01;
  localparam logic [7:0] RST_TEST_PATTERN = 8'h00;
  localparam logic [7:0] RST_DIGITAL_TRIM = 8'h00;
  localparam logic [7:0] RST_OUTPUT_CONFIG = 8'h00;
  localparam logic [7:0] RST_OUT_CLOCK_POL = 8'h00;
  localparam logic [7:0] RST_REFERENCE_SEL = 8'hc0;
  // Implemented bits; open bits store and read as zero.
  localparam logic [7:0] MASK_POWER_MODE = 8'h27;
  localparam logic [7:0] MASK_SAMPLING_CLOCK = 8'h01;
  localparam logic [7:0] MASK_TEST_PATTERN = 8'h37;
  localparam logic [7:0] MASK_DIGITAL_TRIM = 8'h3f;
  localparam logic [7:0] MASK_OUTPUT_CONFIG = 8'hd7;
  localparam logic [7:0] MASK_OUT_CLOCK_POL = 8'h80;
  localparam logic [7:0] MASK_REFERENCE_SEL = 8'hc0;
  // Field positions.
  localparam int POS_PIN_MODE = 5;
  localparam int POS_DCS_EN = 0;
  localparam int POS_PRBS_LONG_HOLD = 5;
  localparam int POS_PRBS_SHORT_HOLD = 4;
  localparam int POS_DRIVE_LSB = 6;
  localparam int POS_OUT_DISABLE = 4;
  localparam int POS_OUT_INVERT = 2;
  localparam int POS_DCO_INVERT = 7;
  localparam int POS_VREF_LSB = 6;
  localparam int POS_SHADOW_COPY = 0;
  // Internal power mode codes.
  localparam logic [2:0] PM_NORMAL = 3'h0;
  localparam logic [2:0] PM_FULL_DOWN = 3'h1;
  localparam logic [2:0] PM_STANDBY = 3'h2;
  localparam logic [2:0] PM_NORMAL_ALT = 3'h3;
  // Output test pattern codes.
  localparam logic [2:0] TP_OFF = 3'h0;
  localparam logic [2:0] TP_MIDSCALE = 3'h1;
  localparam logic [2:0] TP_POS_FULL = 3'h2;
  localparam logic [2:0] TP_NEG_FULL = 3'h3;
  localparam logic [2:0] TP_CHECKER = 3'h4;
  localparam logic [2:0] TP_PRBS_LONG = 3'h5;
  localparam logic [2:0] TP_PRBS_SHORT = 3'h6;
  localparam logic [2:0] TP_TOGGLE = 3'h7;
  // Output format codes.
  localparam logic [1:0] FMT_OFFSET_BIN = 2'h0;
  localparam logic [1:0] FMT_TWOS_COMP = 2'h1;
  localparam logic [1:0] FMT_GRAY = 2'h2;
  // Pattern words, in offset binary.
  localparam logic [11:0] WORD_MIDSCALE = 12'h800;
  localparam logic [11:0] WORD_POS_FULL = 12'hfff;
  localparam logic [11:0] WORD_NEG_FULL = 12'h000;
  localparam logic [11:0] WORD_CHECKER = 12'haaa;
  localparam logic [22:0] SEED_PRBS_LONG = 23'h7f_ffff;
  localparam logic [8:0] SEED_PRBS_SHORT = 9'h1ff;
endpackage : acrb_pkg

// [acrb_output_path.sv]
module acrb_output_path
  import acrb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Conversion data and settings
  input wire logic [11:0] conv_data,
  input wire logic [2:0] test_sel,
  input wire logic prbs_long_hold,
  input wire logic prbs_short_hold,
  input wire logic [1:0] fmt_sel,
  input wire logic invert,
  input wire logic out_disable,
  input wire logic oe_pin_high,
  // Data outputs
  output logic [11:0] data_out_q,
  output logic data_oe_q
);
  logic [22:0] prbs_long_q;
  logic [8:0] prbs_short_q;
  logic phase_q;
  logic [11:0] base;
  logic [11:0] fmt_word;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      prbs_long_q <= SEED_PRBS_LONG;
      prbs_short_q <= SEED_PRBS_SHORT;
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
      // A set hold bit parks the generator at its seed.
      if (prbs_long_hold) begin
        prbs_long_q <= SEED_PRBS_LONG;
      end else begin
        prbs_long_q <= {prbs_long_q[21:0], prbs_long_q[22] ^ prbs_long_q[17]};
      end
      if (prbs_short_hold) begin
        prbs_short_q <= SEED_PRBS_SHORT;
      end else begin
        prbs_short_q <= {prbs_short_q[7:0], prbs_short_q[8] ^ prbs_short_q[4]};
      end
    end
  end

  always_comb begin
    case (test_sel)
      TP_OFF: base = conv_data;
      TP_MIDSCALE: base = WORD_MIDSCALE;
      TP_POS_FULL: base = WORD_POS_FULL;
      TP_NEG_FULL: base = WORD_NEG_FULL;
      TP_CHECKER: base = phase_q ? ~WORD_CHECKER : WORD_CHECKER;
      TP_PRBS_LONG: base = prbs_long_q[22:11];
      TP_PRBS_SHORT: base = {prbs_short_q, prbs_short_q[8:6]};
      TP_TOGGLE: base = phase_q ? WORD_NEG_FULL : WORD_POS_FULL;
      default: base = conv_data;
    endcase
    case (fmt_sel)
      FMT_TWOS_COMP: fmt_word = {~base[11], base[10:0]};
      FMT_GRAY: fmt_word = base ^ {1'b0, base[11:1]};
      default: fmt_word = base;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      data_out_q <= 12'h000;
      data_oe_q <= 1'b0;
    end else begin
      data_out_q <= invert ? ~fmt_word : fmt_word;
      // The register bit only enables the drivers while the enable pin is high.
      data_oe_q <= ~out_disable & oe_pin_high;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_disable_blocks_oe: assert property (out_disable |=> !data_oe_q)
    else $error("outputs enabled while disable bit set");
  a_enable_drives_oe: assert property (!out_disable && oe_pin_high |=> data_oe_q)
    else $error("outputs not enabled");
  a_midscale_word: assert property (test_sel == TP_MIDSCALE && fmt_sel == FMT_OFFSET_BIN && !invert
    |=> data_out_q == 12'h800)
    else $error("midscale word wrong");
  a_twos_full_word: assert property (test_sel == TP_POS_FULL && fmt_sel == FMT_TWOS_COMP && !invert
    |=> data_out_q == 12'h7ff)
    else $error("twos complement full scale wrong");
  a_invert_data: assert property (test_sel == TP_NEG_FULL && fmt_sel == FMT_OFFSET_BIN && invert
    |=> data_out_q == 12'hfff)
    else $error("inverted negative full scale wrong");
  c_prbs_long: cover property (test_sel == TP_PRBS_LONG && data_oe_q);
endmodule : acrb_output_path

// [adc_config_register_bank.sv]
module adc_config_register_bank
  import acrb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Register port from the serial framing logic
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata_q,
  // Device pins
  input wire logic power_down_pin,
  input wire logic output_enable_n_pin,
  // Conversion data
  input wire logic [11:0] conv_data,
  // Power and clocking controls
  output logic power_down_q,
  output logic standby_q,
  output logic duty_cycle_stabilizer_q,
  output logic data_output_clock_invert_q,
  // Analog trims
  output logic [5:0] offset_trim_q,
  output logic [1:0] vref_select_q,
  // Data output controls
  output logic [1:0] drive_cfg_q,
  output logic [11:0] data_out_q,
  output logic data_oe_q
);
  logic [7:0] m_power_q, m_clock_q, m_test_q, m_trim_q, m_out_q, m_phase_q, m_vref_q;
  logic [7:0] act_power_q, act_clock_q, act_test_q, act_trim_q, act_out_q, act_phase_q, act_vref_q;
  logic pd_meta_q, pd_sync_q, oen_meta_q, oen_sync_q;
  logic shadow_copy;
  logic xfer_seen_q;

  assign shadow_copy = reg_wr && reg_addr == ADDR_SHADOW_XFER && reg_wdata[POS_SHADOW_COPY];

  // Both pins are asynchronous to this clock.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pd_meta_q <= 1'b0;
      pd_sync_q <= 1'b0;
      oen_meta_q <= 1'b1;
      oen_sync_q <= 1'b1;
    end else begin
      pd_meta_q <= power_down_pin;
      pd_sync_q <= pd_meta_q;
      oen_meta_q <= output_enable_n_pin;
      oen_sync_q <= oen_meta_q;
    end
  end

  // Master copy: written by the host, not yet in effect.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      m_power_q <= RST_POWER_MODE;
      m_clock_q <= RST_SAMPLING_CLOCK;
      m_test_q <= RST_TEST_PATTERN;
      m_trim_q <= RST_DIGITAL_TRIM;
      m_out_q <= RST_OUTPUT_CONFIG;
      m_phase_q <= RST_OUT_CLOCK_POL;
      m_vref_q <= RST_REFERENCE_SEL;
    end else if (reg_wr) begin
      // Open bits are dropped, so a host that ignores the zero-fill convention cannot set them.
      case (reg_addr)
        ADDR_POWER_MODE: m_power_q <= reg_wdata & MASK_POWER_MODE;
        ADDR_SAMPLING_CLOCK: m_clock_q <= reg_wdata & MASK_SAMPLING_CLOCK;
        ADDR_TEST_PATTERN: m_test_q <= reg_wdata & MASK_TEST_PATTERN;
        ADDR_DIGITAL_TRIM: m_trim_q <= reg_wdata & MASK_DIGITAL_TRIM;
        ADDR_OUTPUT_CONFIG: m_out_q <= reg_wdata & MASK_OUTPUT_CONFIG;
        ADDR_OUT_CLOCK_POL: m_phase_q <= reg_wdata & MASK_OUT_CLOCK_POL;
        ADDR_REFERENCE_SEL: m_vref_q <= reg_wdata & MASK_REFERENCE_SEL;
        default: ;
      endcase
    end
  end

  // Active copy: the whole set moves in one edge, so the analog side never sees a mix.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_power_q <= RST_POWER_MODE;
      act_clock_q <= RST_SAMPLING_CLOCK;
      act_test_q <= RST_TEST_PATTERN;
      act_trim_q <= RST_DIGITAL_TRIM;
      act_out_q <= RST_OUTPUT_CONFIG;
      act_phase_q <= RST_OUT_CLOCK_POL;
      act_vref_q <= RST_REFERENCE_SEL;
    end else if (shadow_copy) begin
      act_power_q <= m_power_q;
      act_clock_q <= m_clock_q;
      act_test_q <= m_test_q;
      act_trim_q <= m_trim_q;
      act_out_q <= m_out_q;
      act_phase_q <= m_phase_q;
      act_vref_q <= m_vref_q;
    end
  end

  // Reads return the master copy; the copy bit is self-clearing and reads zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ADDR_POWER_MODE: reg_rdata_q <= m_power_q;
        ADDR_SAMPLING_CLOCK: reg_rdata_q <= m_clock_q;
        ADDR_TEST_PATTERN: reg_rdata_q <= m_test_q;
        ADDR_DIGITAL_TRIM: reg_rdata_q <= m_trim_q;
        ADDR_OUTPUT_CONFIG: reg_rdata_q <= m_out_q;
        ADDR_OUT_CLOCK_POL: reg_rdata_q <= m_phase_q;
        ADDR_REFERENCE_SEL: reg_rdata_q <= m_vref_q;
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Power state decode.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      power_down_q <= 1'b0;
      standby_q <= 1'b0;
    end else if (pd_sync_q) begin
      power_down_q <= ~act_power_q[POS_PIN_MODE];
      standby_q <= act_power_q[POS_PIN_MODE];
    end else begin
      case (act_power_q[2:0])
        PM_FULL_DOWN: begin
          power_down_q <= 1'b1;
          standby_q <= 1'b0;
        end
        PM_STANDBY: begin
          power_down_q <= 1'b0;
          standby_q <= 1'b1;
        end
        default: begin
          power_down_q <= 1'b0;
          standby_q <= 1'b0;
        end
      endcase
    end
  end

  // Static controls are registered once more so every output leaves from a flip-flop.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      duty_cycle_stabilizer_q <= RST_SAMPLING_CLOCK[POS_DCS_EN];
      data_output_clock_invert_q <= RST_OUT_CLOCK_POL[POS_DCO_INVERT];
      offset_trim_q <= RST_DIGITAL_TRIM[5:0];
      vref_select_q <= RST_REFERENCE_SEL[POS_VREF_LSB +: 2];
      drive_cfg_q <= RST_OUTPUT_CONFIG[POS_DRIVE_LSB +: 2];
    end else begin
      duty_cycle_stabilizer_q <= act_clock_q[POS_DCS_EN];
      data_output_clock_invert_q <= act_phase_q[POS_DCO_INVERT];
      offset_trim_q <= act_trim_q[5:0];
      vref_select_q <= act_vref_q[POS_VREF_LSB +: 2];
      drive_cfg_q <= act_out_q[POS_DRIVE_LSB +: 2];
    end
  end

  acrb_output_path u_output_path (
    .clock(clock),
    .sys_rst(sys_rst),
    .conv_data(conv_data),
    .test_sel(act_test_q[2:0]),
    .prbs_long_hold(act_test_q[POS_PRBS_LONG_HOLD]),
    .prbs_short_hold(act_test_q[POS_PRBS_SHORT_HOLD]),
    .fmt_sel(act_out_q[1:0]),
    .invert(act_out_q[POS_OUT_INVERT]),
    .out_disable(act_out_q[POS_OUT_DISABLE]),
    .oe_pin_high(oen_sync_q),
    .data_out_q(data_out_q),
    .data_oe_q(data_oe_q)
  );

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      xfer_seen_q <= 1'b0;
    end else if (shadow_copy) begin
      xfer_seen_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_pin_overrides_mode: assert property (pd_sync_q && !act_power_q[POS_PIN_MODE]
    |=> power_down_q && !standby_q)
    else $error("power-down pin did not override");
  a_internal_full_down: assert property (!pd_sync_q && act_power_q[2:0] == 3'h1
    |=> power_down_q && !standby_q)
    else $error("internal full power-down not applied");
  a_internal_normal: assert property (!pd_sync_q && (act_power_q[2:0] == 3'h0 || act_power_q[2:0] == 3'h3)
    |=> !power_down_q && !standby_q)
    else $error("normal mode decode wrong");
  a_copy_moves_trim: assert property (shadow_copy |=> act_trim_q == $past(m_trim_q) ##1
    offset_trim_q == $past(m_trim_q[5:0], 2))
    else $error("shadow copy did not move trim");
  a_hold_without_copy: assert property (!shadow_copy |=> $stable(act_out_q) && $stable(act_test_q))
    else $error("active copy changed without transfer");
  a_copy_reads_zero: assert property (reg_rd && reg_addr == ADDR_SHADOW_XFER |=> reg_rdata_q == 8'h00)
    else $error("copy bit did not read zero");
  a_reset_defaults: assert property (!xfer_seen_q |-> vref_select_q == 2'h3 && duty_cycle_stabilizer_q
    && !data_output_clock_invert_q)
    else $error("defaults not held before first transfer");
  a_dco_follows_copy: assert property (shadow_copy |=> ##1
    data_output_clock_invert_q == $past(m_phase_q[POS_DCO_INVERT], 2))
    else $error("output clock polarity not applied");
  a_drive_follows_copy: assert property (shadow_copy |=> ##1 drive_cfg_q == $past(m_out_q[7:6], 2))
    else $error("drive configuration not applied");

  c_pin_standby: cover property (pd_sync_q && act_power_q[POS_PIN_MODE] ##1 standby_q);
  c_shadow_copy: cover property (reg_wr && reg_addr == ADDR_OUTPUT_CONFIG ##[1:4] shadow_copy);
  c_gray_output: cover property (act_out_q[1:0] == 2'h2 && data_oe_q);
endmodule : adc_config_register_bank

// [acrb_host_model.sv]
module acrb_host_model
  import acrb_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata_q
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end

  // Released lines show the inverse of their last value, so a design that samples them late sees garbage.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d & m;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~(d & m);
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    @(posedge clock);
    d = reg_rdata_q;
  endtask : read_reg

  task automatic transfer();
    write_reg(ADDR_SHADOW_XFER, 8'h01, 8'h01);
  endtask : transfer
endmodule : acrb_host_model

// [tb_top.sv]
module tb_top
  import acrb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] ADDRS [8] = '{ADDR_POWER_MODE, ADDR_SAMPLING_CLOCK, ADDR_TEST_PATTERN, ADDR_DIGITAL_TRIM,
    ADDR_OUTPUT_CONFIG, ADDR_OUT_CLOCK_POL, ADDR_REFERENCE_SEL, ADDR_SHADOW_XFER};
  localparam logic [7:0] RSTS [8] = '{RST_POWER_MODE, RST_SAMPLING_CLOCK, RST_TEST_PATTERN, RST_DIGITAL_TRIM,
    RST_OUTPUT_CONFIG, RST_OUT_CLOCK_POL, RST_REFERENCE_SEL, 8'h00};
  localparam logic [7:0] MASKS [8] = '{MASK_POWER_MODE, MASK_SAMPLING_CLOCK, MASK_TEST_PATTERN, MASK_DIGITAL_TRIM,
    MASK_OUTPUT_CONFIG, MASK_OUT_CLOCK_POL, MASK_REFERENCE_SEL, 8'h00};
  localparam logic [1:0] PM_EXP [4] = '{2'h0, 2'h2, 2'h1, 2'h0};
  localparam logic [11:0] TP_EXP [4] = '{12'h123, 12'h800, 12'hfff, 12'h000};
  localparam logic [7:0] FMT_CFG [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
  localparam logic [11:0] FMT_EXP [4] = '{12'h800, 12'h000, 12'hc00, 12'h7ff};

  logic clock = 1'b0;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata_q;
  logic power_down_pin;
  logic output_enable_n_pin;
  logic [11:0] conv_data;
  logic power_down_q;
  logic standby_q;
  logic duty_cycle_stabilizer_q;
  logic data_output_clock_invert_q;
  logic [5:0] offset_trim_q;
  logic [1:0] vref_select_q;
  logic [1:0] drive_cfg_q;
  logic [11:0] data_out_q;
  logic data_oe_q;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [11:0] a;
  logic [11:0] b;

  always #20 clock = ~clock;

  adc_config_register_bank DUT (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .power_down_pin(power_down_pin),
    .output_enable_n_pin(output_enable_n_pin), .conv_data(conv_data), .power_down_q(power_down_q),
    .standby_q(standby_q), .duty_cycle_stabilizer_q(duty_cycle_stabilizer_q),
    .data_output_clock_invert_q(data_output_clock_invert_q), .offset_trim_q(offset_trim_q),
    .vref_select_q(vref_select_q), .drive_cfg_q(drive_cfg_q), .data_out_q(data_out_q), .data_oe_q(data_oe_q));

  acrb_host_model host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  // The whole sequence needs under four hundred cycles; the ceiling leaves wide margin.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rdchk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] v;
    host.read_reg(addr, v);
    chk({4'h0, v}, {4'h0, exp});
  endtask : rdchk

  task automatic cfg(input logic [7:0] addr, input logic [7:0] d, input logic [7:0] m);
    host.write_reg(addr, d, m);
    host.transfer();
    repeat (4) @(posedge clock);
  endtask : cfg

  function automatic logic [11:0] ctl();
    return {4'h0, power_down_q, standby_q, duty_cycle_stabilizer_q, data_output_clock_invert_q, vref_select_q,
      drive_cfg_q};
  endfunction : ctl

  initial begin
    sys_rst = 1'b1;
    power_down_pin = 1'b0;
    output_enable_n_pin = 1'b1;
    conv_data = 12'h123;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    // Let the enable output settle for one edge so it is not read as it launches.
    repeat (2) @(posedge clock);
    chk(ctl(), 12'h02c);
    chk({11'h0, data_oe_q}, 12'h001);
    for (int i = 0; i < 8; i++) begin
      rdchk(ADDRS[i], RSTS[i]);
    end
    rdchk(8'h0a, 8'h00);
    // Open bits are written as ones on purpose here to see that they are dropped.
    for (int i = 0; i < 7; i++) begin
      host.write_reg(ADDRS[i], 8'hff, 8'hff);
      rdchk(ADDRS[i], MASKS[i]);
    end
    chk(ctl(), 12'h02c);
    cfg(ADDR_SHADOW_XFER, 8'hff, 8'hff);
    chk(ctl(), 12'h03f);
    chk({6'h00, offset_trim_q}, 12'h03f);
    rdchk(ADDR_SHADOW_XFER, 8'h00);
    for (int c = 0; c < 4; c++) begin
      cfg(ADDR_POWER_MODE, 8'(c), MASK_POWER_MODE);
      chk({10'h000, power_down_q, standby_q}, {10'h000, PM_EXP[c]});
    end
    power_down_pin <= 1'b1;
    repeat (5) @(posedge clock);
    chk({10'h000, power_down_q, standby_q}, 12'h002);
    cfg(ADDR_POWER_MODE, 8'h20, MASK_POWER_MODE);
    chk({10'h000, power_down_q, standby_q}, 12'h001);
    power_down_pin <= 1'b0;
    cfg(ADDR_POWER_MODE, 8'h00, MASK_POWER_MODE);
    chk({10'h000, power_down_q, standby_q}, 12'h000);
    cfg(ADDR_DIGITAL_TRIM, 8'h1f, MASK_DIGITAL_TRIM);
    chk({6'h00, offset_trim_q}, 12'h01f);
    cfg(ADDR_DIGITAL_TRIM, 8'h20, MASK_DIGITAL_TRIM);
    chk({6'h00, offset_trim_q}, 12'h020);
    cfg(ADDR_SAMPLING_CLOCK, 8'h00, MASK_SAMPLING_CLOCK);
    cfg(ADDR_OUT_CLOCK_POL, 8'h80, MASK_OUT_CLOCK_POL);
    cfg(ADDR_REFERENCE_SEL, 8'h40, MASK_REFERENCE_SEL);
    cfg(ADDR_OUTPUT_CONFIG, 8'h80, MASK_OUTPUT_CONFIG);
    chk(ctl(), 12'h016);
    host.write_reg(ADDR_OUT_CLOCK_POL, 8'h00, MASK_OUT_CLOCK_POL);
    repeat (4) @(posedge clock);
    chk({11'h0, data_output_clock_invert_q}, 12'h001);
    cfg(ADDR_SHADOW_XFER, 8'h01, 8'h01);
    chk({11'h0, data_output_clock_invert_q}, 12'h000);
    output_enable_n_pin <= 1'b1;
    cfg(ADDR_OUTPUT_CONFIG, 8'h00, MASK_OUTPUT_CONFIG);
    chk({11'h0, data_oe_q}, 12'h001);
    for (int c = 0; c < 4; c++) begin
      cfg(ADDR_TEST_PATTERN, 8'(c), MASK_TEST_PATTERN);
      chk(data_out_q, TP_EXP[c]);
    end
    // The format expectations are worked out from the midscale word.
    cfg(ADDR_TEST_PATTERN, 8'h01, MASK_TEST_PATTERN);
    for (int c = 0; c < 4; c++) begin
      cfg(ADDR_OUTPUT_CONFIG, FMT_CFG[c], MASK_OUTPUT_CONFIG);
      chk(data_out_q, FMT_EXP[c]);
    end
    cfg(ADDR_TEST_PATTERN, 8'h02, MASK_TEST_PATTERN);
    cfg(ADDR_OUTPUT_CONFIG, 8'h01, MASK_OUTPUT_CONFIG);
    chk(data_out_q, 12'h7ff);
    cfg(ADDR_TEST_PATTERN, 8'h03, MASK_TEST_PATTERN);
    cfg(ADDR_OUTPUT_CONFIG, 8'h04, MASK_OUTPUT_CONFIG);
    chk(data_out_q, 12'hfff);
    cfg(ADDR_OUTPUT_CONFIG, 8'h00, MASK_OUTPUT_CONFIG);
    for (int k = 0; k < 2; k++) begin
      cfg(ADDR_TEST_PATTERN, k == 0 ? 8'h04 : 8'h07, MASK_TEST_PATTERN);
      @(posedge clock);
      a = data_out_q;
      @(posedge clock);
      b = data_out_q;
      chk(a ^ b, 12'hfff);
      chk((a == 12'hfff || a == 12'haaa) ? b : a, k == 0 ? 12'h555 : 12'h000);
    end
    cfg(ADDR_TEST_PATTERN, 8'h35, MASK_TEST_PATTERN);
    chk(data_out_q, 12'hfff);
    cfg(ADDR_TEST_PATTERN, 8'h36, MASK_TEST_PATTERN);
    chk(data_out_q, 12'hfff);
    cfg(ADDR_OUTPUT_CONFIG, 8'h10, MASK_OUTPUT_CONFIG);
    chk({11'h0, data_oe_q}, 12'h000);
    cfg(ADDR_OUTPUT_CONFIG, 8'h00, MASK_OUTPUT_CONFIG);
    output_enable_n_pin <= 1'b0;
    repeat (5) @(posedge clock);
    chk({11'h0, data_oe_q}, 12'h000);
    final_report();
  end
endmodule : tb_top
